// ===== tmas_consts.svh
/*
  constants for the timer-2 asynchronous status and prescaler control block:
  register addresses, bit positions and reset values.
  assumes it is included by bare name by the package users.
*/
`ifndef TMAS_CONSTS_SVH
`define TMAS_CONSTS_SVH

// cpu data-space addresses
`define TMAS_ADDR_GTC      8'h43
`define TMAS_ADDR_ASTAT    8'hb6
`define TMAS_ADDR_COUNT    8'hb2
`define TMAS_ADDR_CMPA     8'hb3
`define TMAS_ADDR_CMPB     8'hb4
`define TMAS_ADDR_CTLA     8'hb0
`define TMAS_ADDR_CTLB     8'hb1
`define TMAS_ADDR_IFLAG    8'h37
`define TMAS_ADDR_IMASK    8'h70

// general timer control bits
`define TMAS_GTC_HOLD      7
`define TMAS_GTC_ASYRST    1
`define TMAS_GTC_SYNRST    0

// async status bits
`define TMAS_AS_EXTCLK     6
`define TMAS_AS_ASYNC      5
`define TMAS_AS_BUSY_HI    4

// interrupt flag / mask bit
`define TMAS_OVF_BIT       0

// reset values and counter limits
`define TMAS_RST_BYTE      8'h00
`define TMAS_RST_BUSY      5'h00
`define TMAS_BOTTOM        8'h00
`define TMAS_TOP           8'hff

`endif

// ===== tmas_pkg.sv
/*
  types for the timer-2 asynchronous status and prescaler control block.
  assumes tmas_consts.svh is included alongside.
*/
package tmas_pkg;
  // counter direction in phase-correct pwm
  typedef enum logic [0:0] {
    TMAS_UP   = 1'b0,
    TMAS_DOWN = 1'b1
  } tmas_dir_t;
  typedef logic [7:0] tmas_byte_t;
endpackage

// ===== tmas_xfer.sv
/*
  one staged write crossing from the io clock into the timer clock.
  a toggle request is synchronised into the timer domain and an
  acknowledge toggle comes back; busy stands until the ack returns.
  assumes tmr_clk is free-running while the timer is async.
*/
`timescale 1ns/1ps
module tmas_xfer
(
  input  wire logic sys_clk,      // io clock
  input  wire logic rstn,         // async reset, active low
  input  wire logic tmr_clk,      // asynchronous timer clock
  input  wire logic req,          // io-side write pulse (async mode)
  output logic      busy,         // update busy level
  output logic      load          // one timer-clock pulse: take staged value
);
  logic       req_tgl;            // io-side request toggle
  logic [2:0] req_sync;           // timer-side synchroniser plus edge stage
  logic       ack_tgl;            // timer-side acknowledge toggle
  logic [1:0] ack_sync;           // io-side synchroniser
  logic       next_req_tgl;
  logic       next_busy;
  logic       next_load;          // edge seen on the request toggle

  // io-side request toggle and busy level
  always_comb
  begin
    next_req_tgl = req ? ~req_tgl : req_tgl;
    next_busy    = req ? 1'b1 : (busy && (ack_sync[1] != next_req_tgl));
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_tgl  <= 1'b0;
      busy     <= 1'b0;
      ack_sync <= 2'b00;
    end
    else
    begin
      req_tgl  <= next_req_tgl;
      busy     <= next_busy;
      ack_sync <= {ack_sync[0], ack_tgl};
    end
  end

  // load edge: stages 1 and 2 differ, registered so the port is a flop
  always_comb
  begin
    next_load = req_sync[2] ^ req_sync[1];
  end

  // timer-side capture: edge taken between stages 1 and 2 only
  always_ff @(posedge tmr_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      req_sync <= 3'b000;
      ack_tgl  <= 1'b0;
      load     <= 1'b0;
    end
    else
    begin
      req_sync <= {req_sync[1:0], req_tgl};
      ack_tgl  <= req_sync[1];
      load     <= next_load;
    end
  end
endmodule

// ===== tmas_ctrl.sv
/*
  timer-2 status and prescaler control: overflow flag and interrupt
  condition, async clock source selection, update-busy handshakes for the
  five async registers, and the general prescaler reset/hold bits.
  assumes a byte-wide cpu register port (address, write strobe, data) and
  an interrupt-vector acknowledge from the interrupt controller; a simple
  8-bit counter in normal or phase-correct mode sits here as the overflow
  source.
*/
`timescale 1ns/1ps
`include "tmas_consts.svh"

module tmas_ctrl
  import tmas_pkg::*;
(
  input  wire logic        sys_clk,          // io clock, 40 MHz
  input  wire logic        rstn,             // async reset, active low
  input  wire logic        tmr_clk,          // selected async timer clock
  input  wire logic [7:0]  cpu_addr,         // cpu register address
  input  wire logic        cpu_wr,           // write strobe
  input  wire logic        cpu_rd,           // read strobe
  input  wire tmas_pkg::tmas_byte_t cpu_wdata, // write data
  input  wire logic        cpu_status_word,  // global interrupt enable bit
  input  wire logic        irq_ack,          // overflow vector executed
  input  wire logic        pwm_mode,         // counter in phase-correct mode
  input  wire logic        count_tick,       // prescaled count enable
  output tmas_pkg::tmas_byte_t cpu_rdata,    // registered read data
  output logic             overflow_irq,     // interrupt request
  output logic             crystal_enable,   // crystal oscillator runs
  output logic             ext_buffer_enable,// external clock buffer on
  output logic             tmr_clk_async,    // timer clocked from osc input
  output logic             async_prescaler_rst, // timer-2 prescaler reset
  output logic             shared_prescaler_rst,// shared prescaler reset
  output logic [4:0]       load_pulse        // per-register transfer (tmr clk)
);
  import tmas_pkg::*;

  tmas_byte_t counter_value;          // 8-bit counter
  tmas_dir_t  dir;                    // pwm direction
  logic       overflow_flag;
  logic       overflow_irq_enable;
  logic       ext_clock_input_select;
  logic       async_clock_select;
  logic       timer_sync_hold;
  logic       async_prescaler_reset;  // readable bit
  logic       shared_prescaler_reset;
  logic [4:0] busy;                   // count, cmp a, cmp b, ctl a, ctl b
  logic [4:0] wr_async;               // write pulses into async domain
  logic       psr_busy;               // async prescaler reset in flight

  tmas_byte_t next_counter_value;
  tmas_dir_t  next_dir;
  logic       next_overflow_flag;
  logic       next_overflow_irq_enable;
  logic       next_ext_clock_input_select;
  logic       next_async_clock_select;
  logic       next_timer_sync_hold;
  logic       next_async_prescaler_reset;
  logic       next_shared_prescaler_reset;
  tmas_byte_t next_cpu_rdata;
  logic       ovf_event;
  logic       wr_gtc;
  logic       wr_astat;
  logic       next_overflow_irq;         // registered interrupt line
  logic       next_crystal_enable;       // crystal runs next
  logic       next_ext_buffer_enable;    // external buffer on next
  logic       next_tmr_clk_async;        // timer source next
  logic       next_async_prescaler_rst;  // timer-2 prescaler reset next
  logic       next_shared_prescaler_rst; // shared prescaler reset next

  // register write decode
  assign wr_gtc   = cpu_wr && (cpu_addr == `TMAS_ADDR_GTC);
  assign wr_astat = cpu_wr && (cpu_addr == `TMAS_ADDR_ASTAT);

  // async-domain writes only count while async is selected
  always_comb
  begin
    wr_async[4] = cpu_wr && async_clock_select && (cpu_addr == `TMAS_ADDR_COUNT);
    wr_async[3] = cpu_wr && async_clock_select && (cpu_addr == `TMAS_ADDR_CMPA);
    wr_async[2] = cpu_wr && async_clock_select && (cpu_addr == `TMAS_ADDR_CMPB);
    wr_async[1] = cpu_wr && async_clock_select && (cpu_addr == `TMAS_ADDR_CTLA);
    wr_async[0] = cpu_wr && async_clock_select && (cpu_addr == `TMAS_ADDR_CTLB);
  end

  // one transfer handshake per async register
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_xfer
      tmas_xfer u_xfer
      (
        .sys_clk (sys_clk),
        .rstn    (rstn),
        .tmr_clk (tmr_clk),
        .req     (wr_async[gi]),
        .busy    (busy[gi]),
        .load    (load_pulse[gi])
      );
    end
  endgenerate

  // prescaler reset crossing into the async domain
  tmas_xfer u_psr_xfer
  (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .tmr_clk (tmr_clk),
    .req     (wr_gtc && cpu_wdata[`TMAS_GTC_ASYRST] && async_clock_select),
    .busy    (psr_busy),
    .load    ()
  );

  // counter and overflow event
  always_comb
  begin
    next_counter_value = counter_value;
    next_dir           = dir;
    ovf_event          = 1'b0;
    if (cpu_wr && (cpu_addr == `TMAS_ADDR_COUNT))
    begin
      next_counter_value = cpu_wdata;
    end
    else if (count_tick && !async_prescaler_rst && !shared_prescaler_rst)
    begin
      if (!pwm_mode)
      begin
        next_counter_value = counter_value + 8'h01;
        ovf_event          = (counter_value == `TMAS_TOP);
        next_dir           = TMAS_UP;
      end
      else if (dir == TMAS_UP)
      begin
        // turn around at top
        if (counter_value == `TMAS_TOP)
        begin
          next_dir           = TMAS_DOWN;
          next_counter_value = counter_value - 8'h01;
        end
        else
        begin
          next_counter_value = counter_value + 8'h01;
        end
      end
      else
      begin
        // turn around at bottom: flag event
        if (counter_value == `TMAS_BOTTOM)
        begin
          next_dir           = TMAS_UP;
          next_counter_value = counter_value + 8'h01;
          ovf_event          = 1'b1;
        end
        else
        begin
          next_counter_value = counter_value - 8'h01;
        end
      end
    end
  end

  // flags, control bits and read data
  always_comb
  begin
    next_overflow_flag = overflow_flag;
    if (irq_ack || (cpu_wr && (cpu_addr == `TMAS_ADDR_IFLAG)
                    && cpu_wdata[`TMAS_OVF_BIT]))
    begin
      next_overflow_flag = 1'b0;
    end
    if (ovf_event)
    begin
      next_overflow_flag = 1'b1;
    end

    next_overflow_irq_enable = overflow_irq_enable;
    if (cpu_wr && (cpu_addr == `TMAS_ADDR_IMASK))
    begin
      next_overflow_irq_enable = cpu_wdata[`TMAS_OVF_BIT];
    end

    next_ext_clock_input_select = ext_clock_input_select;
    next_async_clock_select     = async_clock_select;
    if (wr_astat)
    begin
      next_ext_clock_input_select = cpu_wdata[`TMAS_AS_EXTCLK];
      next_async_clock_select     = cpu_wdata[`TMAS_AS_ASYNC];
    end

    // prescaler reset bits: hold while in sync mode, else self-clear
    next_timer_sync_hold        = timer_sync_hold;
    next_async_prescaler_reset  = timer_sync_hold ? async_prescaler_reset : 1'b0;
    next_shared_prescaler_reset = timer_sync_hold ? shared_prescaler_reset : 1'b0;
    if (wr_gtc)
    begin
      next_timer_sync_hold = cpu_wdata[`TMAS_GTC_HOLD];
      if (cpu_wdata[`TMAS_GTC_HOLD])
      begin
        next_async_prescaler_reset  = cpu_wdata[`TMAS_GTC_ASYRST];
        next_shared_prescaler_reset = cpu_wdata[`TMAS_GTC_SYNRST];
      end
      else
      begin
        // leaving hold releases both together
        next_async_prescaler_reset  = 1'b0;
        next_shared_prescaler_reset = 1'b0;
      end
    end

    next_cpu_rdata = `TMAS_RST_BYTE;
    if (cpu_rd)
    begin
      unique case (cpu_addr)
        `TMAS_ADDR_GTC:
          next_cpu_rdata = {timer_sync_hold, 5'h00,
                            async_prescaler_reset || psr_busy,
                            shared_prescaler_reset};
        `TMAS_ADDR_ASTAT:
          next_cpu_rdata = {1'b0, ext_clock_input_select, async_clock_select, busy};
        `TMAS_ADDR_COUNT:
          next_cpu_rdata = counter_value;
        `TMAS_ADDR_IFLAG:
          next_cpu_rdata = {7'h00, overflow_flag};
        `TMAS_ADDR_IMASK:
          next_cpu_rdata = {7'h00, overflow_irq_enable};
        default:
          next_cpu_rdata = `TMAS_RST_BYTE;
      endcase
    end
  end

  // output next values, so every port leaves a flop
  always_comb
  begin
    // interrupt line sees this cycle's enable and flag updates
    next_overflow_irq         = cpu_status_word && next_overflow_irq_enable
                                && next_overflow_flag;
    // crystal and external buffer never on together
    next_crystal_enable       = next_async_clock_select
                                && !next_ext_clock_input_select;
    next_ext_buffer_enable    = next_async_clock_select
                                && next_ext_clock_input_select;
    next_tmr_clk_async        = next_async_clock_select;
    // a written one pulses for a cycle even when the bit self-clears
    next_async_prescaler_rst  = next_async_prescaler_reset
                                || (wr_gtc && cpu_wdata[`TMAS_GTC_ASYRST]);
    next_shared_prescaler_rst = next_shared_prescaler_reset
                                || (wr_gtc && cpu_wdata[`TMAS_GTC_SYNRST]);
  end

  // register all state and outputs
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      counter_value          <= `TMAS_RST_BYTE;
      dir                    <= TMAS_UP;
      overflow_flag          <= 1'b0;
      overflow_irq_enable    <= 1'b0;
      ext_clock_input_select <= 1'b0;
      async_clock_select     <= 1'b0;
      timer_sync_hold        <= 1'b0;
      async_prescaler_reset  <= 1'b0;
      shared_prescaler_reset <= 1'b0;
      cpu_rdata              <= `TMAS_RST_BYTE;
      overflow_irq           <= 1'b0;
      crystal_enable         <= 1'b0;
      ext_buffer_enable      <= 1'b0;
      tmr_clk_async          <= 1'b0;
      async_prescaler_rst    <= 1'b0;
      shared_prescaler_rst   <= 1'b0;
    end
    else
    begin
      counter_value          <= next_counter_value;
      dir                    <= next_dir;
      overflow_flag          <= next_overflow_flag;
      overflow_irq_enable    <= next_overflow_irq_enable;
      ext_clock_input_select <= next_ext_clock_input_select;
      async_clock_select     <= next_async_clock_select;
      timer_sync_hold        <= next_timer_sync_hold;
      async_prescaler_reset  <= next_async_prescaler_reset;
      shared_prescaler_reset <= next_shared_prescaler_reset;
      cpu_rdata              <= next_cpu_rdata;
      overflow_irq           <= next_overflow_irq;
      crystal_enable         <= next_crystal_enable;
      ext_buffer_enable      <= next_ext_buffer_enable;
      tmr_clk_async          <= next_tmr_clk_async;
      async_prescaler_rst    <= next_async_prescaler_rst;
      shared_prescaler_rst   <= next_shared_prescaler_rst;
    end
  end
endmodule

// ===== tmas_ctrl_props.sv
/*
  port checker for the timer-2 status and prescaler control block.
  assumes it is bound to tmas_ctrl and that all checks run on the io clock.
*/
`timescale 1ns/1ps
`include "tmas_consts.svh"
module tmas_ctrl_props
(
  input wire logic                 sys_clk,
  input wire logic                 rstn,
  input wire logic [7:0]           cpu_addr,
  input wire logic                 cpu_wr,
  input wire tmas_pkg::tmas_byte_t cpu_wdata,
  input wire logic                 cpu_status_word,
  input wire logic                 irq_ack,
  input wire logic                 count_tick,
  input wire logic                 overflow_irq,
  input wire logic                 crystal_enable,
  input wire logic                 ext_buffer_enable,
  input wire logic                 tmr_clk_async,
  input wire logic                 async_prescaler_rst,
  input wire logic                 shared_prescaler_rst,
  input wire logic [4:0]           load_pulse
);
  import tmas_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  logic hold_q;       // shadow of the hold bit
  logic next_hold_q;  // next shadow value
  wire  gtc_wr = cpu_wr && cpu_addr == `TMAS_ADDR_GTC;    // control write
  wire  ast_wr = cpu_wr && cpu_addr == `TMAS_ADDR_ASTAT;  // status write
  // track the last written hold bit
  always_comb
    next_hold_q = gtc_wr ? cpu_wdata[`TMAS_GTC_HOLD] : hold_q;
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
      hold_q <= 1'b0;
    else
      hold_q <= next_hold_q;
  // one-cycle pulse, then low
  sequence s_one(x);
    x ##1 !x;
  endsequence
  // bus quiet for four cycles
  sequence s_quiet;
    (!cpu_wr) [*4];
  endsequence
  a_irq_needs_gie: assert property (!cpu_status_word ##1 !cpu_status_word |-> !overflow_irq)
    else $error("overflow irq without global enable");
  a_ack_clears_irq: assert property (irq_ack && !count_tick ##1 !count_tick
    |-> ##[0:1] !overflow_irq)
    else $error("overflow irq stays after vector ack");
  a_sync_rst_pulse: assert property (gtc_wr && cpu_wdata == 8'h01 && !hold_q
    |-> ##1 s_one(shared_prescaler_rst))
    else $error("shared prescaler reset is not a single pulse");
  a_asy_rst_pulse: assert property (gtc_wr && cpu_wdata == 8'h02 && !hold_q && !tmr_clk_async
    |-> ##1 s_one(async_prescaler_rst))
    else $error("async prescaler reset is not a single pulse");
  a_hold_keeps_rst: assert property (gtc_wr && cpu_wdata[`TMAS_GTC_HOLD]
    && cpu_wdata[`TMAS_GTC_SYNRST] ##1 s_quiet
    |-> shared_prescaler_rst)
    else $error("held prescaler reset dropped");
  a_hold_clear_rst: assert property (hold_q && gtc_wr && cpu_wdata == 8'h00
    |-> ##1 !shared_prescaler_rst ##[0:8] !async_prescaler_rst)
    else $error("prescaler resets not cleared with hold");
  a_ext_stops_xtal: assert property (ext_buffer_enable |-> !crystal_enable && tmr_clk_async)
    else $error("external buffer with crystal running");
  a_src_follows_wr: assert property (ast_wr ##1 !cpu_wr ##1 !cpu_wr
    |-> tmr_clk_async == $past(cpu_wdata[`TMAS_AS_ASYNC], 2)
        && ext_buffer_enable == ($past(cpu_wdata[`TMAS_AS_EXTCLK], 2)
        && $past(cpu_wdata[`TMAS_AS_ASYNC], 2)))
    else $error("clock source does not follow status write");
  a_count_load_due: assert property (cpu_wr && cpu_addr == `TMAS_ADDR_COUNT && tmr_clk_async
    |-> ##[1:40] load_pulse[4])
    else $error("counter staged value never loaded");
endmodule

bind tmas_ctrl tmas_ctrl_props u_props (.sys_clk(sys_clk), .rstn(rstn), .cpu_addr(cpu_addr),
  .cpu_wr(cpu_wr), .cpu_wdata(cpu_wdata), .cpu_status_word(cpu_status_word),
  .irq_ack(irq_ack), .count_tick(count_tick), .overflow_irq(overflow_irq),
  .crystal_enable(crystal_enable), .ext_buffer_enable(ext_buffer_enable),
  .tmr_clk_async(tmr_clk_async), .async_prescaler_rst(async_prescaler_rst),
  .shared_prescaler_rst(shared_prescaler_rst), .load_pulse(load_pulse));

// ===== tmas_ctrl_tb.sv
/*
  self-checking bench for tmas_ctrl through its byte register port.
  assumes a 40 MHz io clock and a slower free-running timer clock.
*/
`timescale 1ns/1ps
`include "tmas_consts.svh"
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tmas_ctrl_tb;
  import tmas_pkg::*;
  logic       sys_clk, tmr_clk, rstn, cpu_wr, cpu_rd;  // clocks and strobes
  logic       gie, irq_ack, pwm_mode, count_tick;      // side inputs
  logic [7:0] cpu_addr;                                // register address
  tmas_byte_t cpu_wdata, cpu_rdata;                    // data bytes
  logic       irq, xtal, extb, asy, arst, srst;        // status outputs
  logic [4:0] load;                                    // transfer pulses
  int         fail_count, comparisons, cyc;            // tallies
  logic [4:0] seen_load = 5'h00;                       // transfers seen so far
  tmas_byte_t regs[5] = '{`TMAS_ADDR_COUNT, `TMAS_ADDR_CMPA, `TMAS_ADDR_CMPB,
                          `TMAS_ADDR_CTLA, `TMAS_ADDR_CTLB};  // busy sources
  tmas_ctrl u_dut (.sys_clk(sys_clk), .rstn(rstn), .tmr_clk(tmr_clk), .cpu_addr(cpu_addr),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_wdata(cpu_wdata), .cpu_status_word(gie),
    .irq_ack(irq_ack), .pwm_mode(pwm_mode), .count_tick(count_tick), .cpu_rdata(cpu_rdata),
    .overflow_irq(irq), .crystal_enable(xtal), .ext_buffer_enable(extb),
    .tmr_clk_async(asy), .async_prescaler_rst(arst), .shared_prescaler_rst(srst),
    .load_pulse(load));
  // io clock 25 ns, timer clock unrelated 97 ns
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  initial
  begin
    tmr_clk = 1'b0;
    forever #48.5 tmr_clk = ~tmr_clk;
  end
  // verdict and end of run
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // hang guard
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      fail_count++;
      finish_test();
    end
  end
  // sticky record of every staged-value transfer
  always @(posedge sys_clk)
    seen_load <= seen_load | load;
  task automatic idle(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  // one-cycle write strobe
  task automatic wr(input tmas_byte_t a, input tmas_byte_t d);
    cpu_addr = a;
    cpu_wdata = d;
    cpu_wr = 1'b1;
    idle(1);
    cpu_wr = 1'b0;
    idle(1);
  endtask
  // read, data stands the cycle after the strobe
  task automatic rd(input tmas_byte_t a, input tmas_byte_t e, input string nm);
    cpu_addr = a;
    cpu_rd = 1'b1;
    idle(1);
    cpu_rd = 1'b0;
    `CHK(nm, e, cpu_rdata)
    idle(1);
  endtask
  // count steps, one per cycle
  task automatic tick(input int n);
    count_tick = 1'b1;
    idle(n);
    count_tick = 1'b0;
  endtask
  initial
  begin
    {rstn, cpu_wr, cpu_rd, gie, irq_ack, pwm_mode, count_tick} = '0;
    cpu_addr = 8'h00;
    cpu_wdata = 8'h00;
    idle(8);
    rstn = 1'b1;
    idle(1);
    // reset values, unmapped place ignored
    wr(8'h55, 8'hff);
    rd(`TMAS_ADDR_GTC, 8'h00, "gtc");
    rd(`TMAS_ADDR_ASTAT, 8'h00, "astat");
    rd(8'h55, 8'h00, "unmapped");
    $display("test reset done");
    // normal overflow, enables and clears
    wr(`TMAS_ADDR_IMASK, 8'h01);
    rd(`TMAS_ADDR_IMASK, 8'h01, "mask");
    gie = 1'b1;
    tick(255);
    rd(`TMAS_ADDR_IFLAG, 8'h00, "flag");
    tick(1);
    rd(`TMAS_ADDR_IFLAG, 8'h01, "flag");
    `CHK("irq", 1'b1, irq)
    gie = 1'b0;
    idle(2);
    `CHK("irq", 1'b0, irq)
    gie = 1'b1;
    wr(`TMAS_ADDR_IMASK, 8'h00);
    idle(2);
    `CHK("irq", 1'b0, irq)
    wr(`TMAS_ADDR_IMASK, 8'h01);
    wr(`TMAS_ADDR_IFLAG, 8'h01);
    rd(`TMAS_ADDR_IFLAG, 8'h00, "flag");
    tick(256);
    irq_ack = 1'b1;
    idle(1);
    irq_ack = 1'b0;
    rd(`TMAS_ADDR_IFLAG, 8'h00, "flag");
    $display("test overflow done");
    // phase-correct: flag only at the bottom turn
    pwm_mode = 1'b1;
    tick(400);
    rd(`TMAS_ADDR_IFLAG, 8'h00, "flag");
    tick(120);
    rd(`TMAS_ADDR_IFLAG, 8'h01, "flag");
    rd(`TMAS_ADDR_COUNT, 8'h0a, "count");
    pwm_mode = 1'b0;
    $display("test pwm done");
    // prescaler resets, free and held
    wr(`TMAS_ADDR_GTC, 8'h01);
    idle(3);
    rd(`TMAS_ADDR_GTC, 8'h00, "gtc");
    wr(`TMAS_ADDR_GTC, 8'h02);
    idle(3);
    rd(`TMAS_ADDR_GTC, 8'h00, "gtc");
    wr(`TMAS_ADDR_GTC, 8'h83);
    idle(4);
    rd(`TMAS_ADDR_GTC, 8'h83, "gtc");
    `CHK("arst", 1'b1, arst)
    wr(`TMAS_ADDR_GTC, 8'h00);
    idle(2);
    rd(`TMAS_ADDR_GTC, 8'h00, "gtc");
    `CHK("srst", 1'b0, srst)
    $display("test prescaler done");
    // clock source: ext select first, then async
    wr(`TMAS_ADDR_ASTAT, 8'h40);
    wr(`TMAS_ADDR_ASTAT, 8'h60);
    idle(2);
    `CHK("extb", 1'b1, extb)
    `CHK("xtal", 1'b0, xtal)
    wr(`TMAS_ADDR_ASTAT, 8'h20);
    idle(2);
    `CHK("xtal", 1'b1, xtal)
    `CHK("asy", 1'b1, asy)
    // rewrite each timer register, busy until crossed
    for (int i = 0; i < 5; i++)
    begin
      wr(regs[i], 8'h10);
      rd(`TMAS_ADDR_ASTAT, 8'h20 | (8'h01 << (4 - i)), "busy");
      idle(40);
      rd(`TMAS_ADDR_ASTAT, 8'h20, "busy");
    end
    `CHK("load", 5'h1f, seen_load)
    wr(`TMAS_ADDR_COUNT, 8'h00);
    wr(`TMAS_ADDR_CMPA, 8'h00);
    rd(`TMAS_ADDR_ASTAT, 8'h38, "busy");
    idle(40);
    wr(`TMAS_ADDR_GTC, 8'h02);
    rd(`TMAS_ADDR_GTC, 8'h02, "gtc");
    idle(40);
    rd(`TMAS_ADDR_GTC, 8'h00, "gtc");
    wr(`TMAS_ADDR_ASTAT, 8'h00);
    idle(2);
    `CHK("asy", 1'b0, asy)
    $display("test async done");
    finish_test();
  end
endmodule
